//--- logic/rmct_defs.vh
// Constants for the call, timer, standby and status-test execution block
`ifndef RMCT_DEFS_VH
`define RMCT_DEFS_VH
`define RMCT_OP_NONE     4'h0
`define RMCT_OP_CALL     4'h1
`define RMCT_OP_RET      4'h2
`define RMCT_OP_RD_THI   4'h3
`define RMCT_OP_RD_TLO   4'h4
`define RMCT_OP_WR_THI   4'h5
`define RMCT_OP_WR_TLO   4'h6
`define RMCT_OP_LD_TIMM  4'h7
`define RMCT_OP_LD_TROM  4'h8
`define RMCT_OP_STANDBY  4'h9
`define RMCT_OP_STATUS_TEST_OP_REG 4'hA
`define RMCT_OP_STATUS_TEST_OP_IMM 4'hB
`define RMCT_OP_CARRY_IF_ALL_ONES_OP     4'hC
`define RMCT_SP_RESET    1'h0
`define RMCT_PC_RESET    10'h000
`define RMCT_TIMER_RESET 10'h000
`define RMCT_CALL_CYCLES 2'h2
`define RMCT_PRESC_SLOW  8'h80
`define RMCT_PRESC_FAST  8'h40
`endif

//--- logic/rmct_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`include "rmct_defs.vh"
module rmct_sync #(
	parameter W = 1
) (
	input  wire         core_clk,
	input  wire         rst,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] stage1;
	reg [W-1:0] stage2;
	reg [W-1:0] stage3;
	always @(posedge core_clk) begin
		if (rst) begin
			stage1   <= {W{1'b0}};
			stage2   <= {W{1'b0}};
			stage3   <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			// Change accepted only once second and third stages agree
			if (stage2 == stage3)
				sync_out <= stage3;
		end
	end
endmodule

//--- logic/rmct_exec.v
// Execution unit for call, return, timer, standby, status test, carry ops
`timescale 1ns/10ps
`include "rmct_defs.vh"
module rmct_exec (
	input  wire        core_clk,
	input  wire        rst,
	input  wire        op_valid,
	input  wire [3:0]  op_code,
	input  wire [9:0]  op_operand,
	input  wire [3:0]  acc_in,
	input  wire [3:0]  low_bank_register,
	input  wire [1:0]  rom_page_control,
	input  wire [7:0]  reg_pair,
	input  wire [9:0]  rom_data,
	input  wire        timer_slow,
	input  wire        sense_input_a,
	input  wire        sense_input_b,
	input  wire [7:0]  key_io_inputs,
	input  wire [3:0]  key_inputs,
	output reg         op_busy,
	output reg         op_done,
	output reg  [9:0]  pc,
	output reg  [9:0]  return_address_reg,
	output reg         stack_pointer,
	output reg         internal_reset,
	output reg  [3:0]  acc_out,
	output reg         acc_we,
	output reg         carry_flag,
	output reg         carry_we,
	output reg         test_flag,
	output reg  [9:0]  timer_value,
	output reg         timer_expired,
	output reg  [9:0]  rom_addr,
	output reg         standby,
	output reg  [3:0]  release_cond
);
	localparam ST_IDLE  = 3'b001;
	localparam ST_CALL2 = 3'b010;
	localparam ST_SLEEP = 3'b100;

	reg  [2:0] state;
	reg  [9:0] call_target;
	reg  [9:0] tcount;
	reg  [7:0] presc;
	wire       s_a;
	wire       s_b;
	wire [7:0] s_kio;
	wire [3:0] s_k;

	rmct_sync #(.W(14)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.async_in ({sense_input_a, sense_input_b, key_io_inputs,
			key_inputs}),
		.sync_out ({s_a, s_b, s_kio, s_k})
	);

	// Status vector: bit3 sense, bit2 key io, bit1 keys, bit0 timer
	wire [3:0] status_now = {s_a | s_b, |s_kio, |s_k, timer_expired};

	function [3:0] keep_low_ones;
		input [3:0] a;
		begin
			if (!a[0])
				keep_low_ones = 4'h0;
			else if (!a[1])
				keep_low_ones = 4'h1;
			else if (!a[2])
				keep_low_ones = 4'h3;
			else if (!a[3])
				keep_low_ones = 4'h7;
			else
				keep_low_ones = 4'hF;
		end
	endfunction

	wire [7:0] presc_top = timer_slow ? `RMCT_PRESC_SLOW : `RMCT_PRESC_FAST;
	wire       go = op_valid && (state == ST_IDLE);

	// Timer up-counter, also cleared to zero on each timer write or load
	always @(posedge core_clk) begin
		if (rst) begin
			tcount        <= `RMCT_TIMER_RESET;
			presc         <= 8'h00;
			timer_expired <= 1'b0;
		end else if (go && (op_code == `RMCT_OP_WR_THI ||
				op_code == `RMCT_OP_WR_TLO ||
				op_code == `RMCT_OP_LD_TIMM ||
				op_code == `RMCT_OP_LD_TROM)) begin
			tcount        <= 10'h000;
			presc         <= 8'h00;
			timer_expired <= 1'b0;
		end else if (presc == presc_top - 8'h01) begin
			presc <= 8'h00;
			if (tcount == timer_value) begin
				tcount        <= 10'h000;
				timer_expired <= 1'b1;
			end else begin
				tcount <= tcount + 10'h001;
			end
		end else begin
			presc <= presc + 8'h01;
		end
	end

	always @(posedge core_clk) begin
		if (rst) begin
			state              <= ST_IDLE;
			op_busy            <= 1'b0;
			op_done            <= 1'b0;
			pc                 <= `RMCT_PC_RESET;
			return_address_reg <= `RMCT_PC_RESET;
			stack_pointer      <= `RMCT_SP_RESET;
			internal_reset     <= 1'b0;
			acc_out            <= 4'h0;
			acc_we             <= 1'b0;
			carry_flag         <= 1'b0;
			carry_we           <= 1'b0;
			test_flag          <= 1'b0;
			timer_value        <= `RMCT_TIMER_RESET;
			rom_addr           <= 10'h000;
			standby            <= 1'b0;
			release_cond       <= 4'h0;
			call_target        <= 10'h000;
		end else begin
			op_done        <= 1'b0;
			acc_we         <= 1'b0;
			carry_we       <= 1'b0;
			internal_reset <= 1'b0;
			// Indirect address tracks page and pair for the ROM lookup
			rom_addr <= {rom_page_control, reg_pair};
			case (state)
			ST_IDLE: begin
				if (op_valid) begin
					case (op_code)
					`RMCT_OP_CALL: begin
						if (stack_pointer) begin
							internal_reset <= 1'b1;
							stack_pointer  <= `RMCT_SP_RESET;
							pc             <= `RMCT_PC_RESET;
							op_done        <= 1'b1;
						end else begin
							stack_pointer      <= 1'b1;
							return_address_reg <= pc;
							call_target        <= op_operand;
							op_busy            <= 1'b1;
							state              <= ST_CALL2;
						end
					end
					`RMCT_OP_RET: begin
						op_done <= 1'b1;
						if (!stack_pointer) begin
							internal_reset <= 1'b1;
							pc             <= `RMCT_PC_RESET;
						end else begin
							pc            <= return_address_reg;
							stack_pointer <= 1'b0;
						end
					end
					`RMCT_OP_RD_THI: begin
						acc_out <= timer_value[9:6];
						acc_we  <= 1'b1;
						op_done <= 1'b1;
					end
					`RMCT_OP_RD_TLO: begin
						acc_out <= timer_value[5:2];
						acc_we  <= 1'b1;
						op_done <= 1'b1;
					end
					`RMCT_OP_WR_THI: begin
						timer_value[9:6] <= acc_in;
						timer_value[1]   <= 1'b0;
						op_done          <= 1'b1;
					end
					`RMCT_OP_WR_TLO: begin
						timer_value[5:2] <= acc_in;
						timer_value[0]   <= 1'b0;
						op_done          <= 1'b1;
					end
					`RMCT_OP_LD_TIMM: begin
						// Operand order t1 t9 t8 t7 t6 t0 t5 t4 t3 t2
						timer_value <= {op_operand[8:5], op_operand[3:0],
							op_operand[9], op_operand[4]};
						op_done <= 1'b1;
					end
					`RMCT_OP_LD_TROM: begin
						timer_value <= rom_data;
						op_done     <= 1'b1;
					end
					`RMCT_OP_STANDBY: begin
						release_cond <= op_operand[3:0];
						standby      <= 1'b1;
						op_busy      <= 1'b1;
						state        <= ST_SLEEP;
					end
					`RMCT_OP_STATUS_TEST_OP_REG: begin
						test_flag <= |(status_now & low_bank_register);
						op_done   <= 1'b1;
					end
					`RMCT_OP_STATUS_TEST_OP_IMM: begin
						test_flag <= |(status_now & op_operand[3:0]);
						op_done   <= 1'b1;
					end
					`RMCT_OP_CARRY_IF_ALL_ONES_OP: begin
						carry_flag <= (acc_in == 4'hF);
						carry_we   <= 1'b1;
						acc_out    <= keep_low_ones(acc_in);
						acc_we     <= 1'b1;
						op_done    <= 1'b1;
					end
					default: begin
						op_done <= 1'b1;
					end
					endcase
				end
			end
			ST_CALL2: begin
				pc      <= call_target;
				op_busy <= 1'b0;
				op_done <= 1'b1;
				state   <= ST_IDLE;
			end
			ST_SLEEP: begin
				// Condition held steady until a selected status matches
				if (|(status_now & release_cond)) begin
					standby <= 1'b0;
					op_busy <= 1'b0;
					op_done <= 1'b1;
					state   <= ST_IDLE;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

//--- test/rmct_exec_asserts.sv
// Port checker for the execution block
`timescale 1ns/10ps
`include "rmct_defs.vh"
module rmct_exec_asserts (
	input logic       core_clk,
	input logic       rst,
	input logic       op_valid,
	input logic [3:0] op_code,
	input logic [9:0] op_operand,
	input logic [3:0] acc_in,
	input logic       op_busy,
	input logic       op_done,
	input logic [9:0] pc,
	input logic [9:0] return_address_reg,
	input logic       stack_pointer,
	input logic       internal_reset,
	input logic [3:0] acc_out,
	input logic       acc_we,
	input logic       carry_flag,
	input logic       carry_we,
	input logic [9:0] timer_value,
	input logic       standby,
	input logic [3:0] release_cond
);
	logic [9:0] tq;
	logic [9:0] oq;
	logic [3:0] aq;
	// Copies one cycle back, so slices need no sampled-value call
	always @(posedge core_clk) {tq, oq, aq} <= {timer_value, op_operand, acc_in};
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence s_tk(logic [3:0] c);
		op_valid && !op_busy && op_code == c;
	endsequence
	sequence s_push;
		stack_pointer && op_busy ##1 op_done;
	endsequence
	property p_call;
		s_tk(`RMCT_OP_CALL) ##0 !stack_pointer |=> s_push
			##0 pc == $past(op_operand, 2);
	endproperty
	property p_ovf;
		s_tk(`RMCT_OP_CALL) ##0 stack_pointer |=> internal_reset && pc == 0;
	endproperty
	property p_ret;
		s_tk(`RMCT_OP_RET) ##0 stack_pointer |=> !stack_pointer
			&& pc == $past(return_address_reg);
	endproperty
	property p_unf;
		s_tk(`RMCT_OP_RET) ##0 !stack_pointer |=> internal_reset;
	endproperty
	property p_rd;
		s_tk(`RMCT_OP_RD_THI) |=> acc_we && acc_out == tq[9:6];
	endproperty
	property p_wr;
		s_tk(`RMCT_OP_WR_THI) |=> timer_value[9:6] == aq && !timer_value[1];
	endproperty
	property p_imm;
		s_tk(`RMCT_OP_LD_TIMM) |=>
			timer_value == {oq[8:5], oq[3:0], oq[9], oq[4]};
	endproperty
	property p_carry_if_all_ones_op;
		s_tk(`RMCT_OP_CARRY_IF_ALL_ONES_OP) |=> carry_we && carry_flag == (aq == 4'hF);
	endproperty
	property p_stdby;
		s_tk(`RMCT_OP_STANDBY) |=> standby && op_busy
			&& release_cond == oq[3:0];
	endproperty
	a_stdby: assert property (p_stdby) else $error("standby wrong");
	a_call: assert property (p_call) else $error("call sequence wrong");
	a_ovf: assert property (p_ovf) else $error("no overflow reset");
	a_ret: assert property (p_ret) else $error("return wrong");
	a_unf: assert property (p_unf) else $error("no underflow reset");
	a_rd: assert property (p_rd) else $error("timer read wrong");
	a_wr: assert property (p_wr) else $error("timer write wrong");
	a_imm: assert property (p_imm) else $error("timer load wrong");
	a_carry_if_all_ones_op: assert property (p_carry_if_all_ones_op) else $error("carry wrong");
endmodule

//--- test/rmct_partner.sv
// Program memory and key and sense pin model
`timescale 1ns/10ps
module rmct_partner (
	input  logic [9:0]  rom_addr,
	input  logic [13:0] pin_req,
	output logic [9:0]  rom_data,
	output logic        sense_input_a,
	output logic        sense_input_b,
	output logic [7:0]  key_io_inputs,
	output logic [3:0]  key_inputs
);
	// Contents differ from the address so a wrong fetch shows
	assign rom_data = ~rom_addr;
	assign {sense_input_a, sense_input_b, key_io_inputs, key_inputs} = pin_req;
endmodule

//--- test/tb_remote_mcu_call_timer_status_ops.sv
// Testbench for the call, timer, standby and status execution block
`timescale 1ns/10ps
`include "rmct_defs.vh"
module tb_remote_mcu_call_timer_status_ops;
	logic core_clk, rst, op_valid, timer_slow, op_busy, op_done, standby;
	logic sense_input_a, sense_input_b, stack_pointer, internal_reset;
	logic acc_we, carry_flag, carry_we, test_flag, timer_expired;
	logic [3:0] op_code, acc_in, low_bank_register, key_inputs, acc_out, e;
	logic [3:0] release_cond;
	logic [1:0] rom_page_control;
	logic [7:0] reg_pair, key_io_inputs;
	logic [9:0] op_operand, rom_data, pc, return_address_reg, rom_addr;
	logic [9:0] timer_value;
	logic [13:0] pin_req;
	int err_total, checks_done, i;
	rmct_exec dut_u (.*);
	rmct_partner u_far (.*);
	task chk(string n, logic [9:0] x, logic [9:0] g);
		checks_done++;
		if (g !== x) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, x, g);
		end
	endtask
	task op(logic [3:0] c, logic [9:0] d);
		// An idle edge keeps the last release apart from the next request
		@(posedge core_clk) #1;
		{op_code, op_operand, op_valid} = {c, d, 1'b1};
		@(posedge core_clk) #1;
		op_valid = 0;
		for (i = 0; i < 40 && op_done !== 1; i++) @(posedge core_clk) #1;
	endtask
	task complete_run;
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		core_clk = 0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#125000;
		err_total++;
		complete_run;
	end
	initial begin
		rst = 1;
		{op_valid, op_code, op_operand, acc_in, timer_slow} = 0;
		{low_bank_register, rom_page_control, reg_pair, pin_req} = 0;
		repeat (20) @(posedge core_clk);
		#1 rst = 0;
		op(`RMCT_OP_CALL, 10'h2A5);
		chk("pc", 10'h2A5, pc);
		chk("sp", 1, stack_pointer);
		chk("ret", 10'h000, return_address_reg);
		op(`RMCT_OP_CALL, 10'h155);
		chk("ireset", 1, internal_reset);
		chk("pc", 10'h000, pc);
		chk("sp", 0, stack_pointer);
		op(`RMCT_OP_RET, 0);
		chk("ireset", 1, internal_reset);
		op(`RMCT_OP_CALL, 10'h0F0);
		op(`RMCT_OP_RET, 0);
		chk("pc", 10'h000, pc);
		chk("sp", 0, stack_pointer);
		op(`RMCT_OP_LD_TIMM, 10'h3A5);
		chk("timer", 10'h356, timer_value);
		op(`RMCT_OP_RD_THI, 0);
		chk("acc", 4'hD, acc_out);
		op(`RMCT_OP_RD_TLO, 0);
		chk("acc", 4'h5, acc_out);
		op(`RMCT_OP_LD_TIMM, 10'h3FF);
		acc_in = 4'hA;
		op(`RMCT_OP_WR_THI, 0);
		chk("timer", 10'h2BD, timer_value);
		acc_in = 4'h3;
		op(`RMCT_OP_WR_TLO, 0);
		chk("timer", 10'h28C, timer_value);
		{rom_page_control, reg_pair} = 10'h23C;
		@(posedge core_clk) #1;
		op(`RMCT_OP_LD_TROM, 0);
		chk("timer", 10'h1C3, timer_value);
		// Slow prescale with value 0, fast with value 1: both 128 clocks
		for (int s = 0; s < 2; s++) begin
			timer_slow = (s == 0);
			op(`RMCT_OP_LD_TIMM, s ? 10'h010 : 10'h000);
			repeat (127) @(posedge core_clk);
			#1 chk("expired", 0, timer_expired);
			@(posedge core_clk) #1;
			chk("expired", 1, timer_expired);
		end
		op(`RMCT_OP_STATUS_TEST_OP_IMM, 1);
		chk("flag", 1, test_flag);
		op(`RMCT_OP_STATUS_TEST_OP_IMM, 8);
		chk("flag", 0, test_flag);
		pin_req = 1;
		repeat (8) @(posedge core_clk);
		#1 low_bank_register = 2;
		op(`RMCT_OP_STATUS_TEST_OP_REG, 0);
		chk("flag", 1, test_flag);
		low_bank_register = 8;
		op(`RMCT_OP_STATUS_TEST_OP_REG, 0);
		chk("flag", 0, test_flag);
		pin_req = 14'h0010;
		repeat (8) @(posedge core_clk);
		#1 low_bank_register = 4;
		op(`RMCT_OP_STATUS_TEST_OP_REG, 0);
		chk("flag", 1, test_flag);
		low_bank_register = 2;
		op(`RMCT_OP_STATUS_TEST_OP_REG, 0);
		chk("flag", 0, test_flag);
		fork
			op(`RMCT_OP_STANDBY, 8);
			begin
				repeat (6) @(posedge core_clk);
				#1 chk("standby", 1, standby);
				chk("cond", 8, release_cond);
				pin_req[13] = 1;
			end
		join
		chk("standby", 0, standby);
		for (int k = 0; k < 16; k++) begin
			acc_in = k;
			e = acc_in & ~(acc_in + 4'h1);
			op(`RMCT_OP_CARRY_IF_ALL_ONES_OP, 0);
			chk("acc", e, acc_out);
			chk("carry", k == 15, carry_flag);
		end
		complete_run;
	end
endmodule
bind rmct_exec rmct_exec_asserts u_chk (.*);
